// File: lamp_pkg.sv
// shared constants and types for the status lamp logic
package lamp_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned SLOW_BLINK_HZ  = 1;
    localparam int unsigned FAST_BLINK_HZ  = 4;
    // half periods in cycles: one toggle per half period
    localparam int unsigned SLOW_HALF_CYC  = CLK_HZ / (2 * SLOW_BLINK_HZ);
    localparam int unsigned FAST_HALF_CYC  = CLK_HZ / (2 * FAST_BLINK_HZ);
    localparam int unsigned NUM_CHANNELS   = 2;
    localparam int unsigned SYNC_STAGES    = 3;

    // lamp pattern chosen for the health / operational pair
    typedef enum logic [3:0] {
        PAT_OFF        = 4'h0,
        PAT_DIAG       = 4'h1,
        PAT_FATAL      = 4'h2,
        PAT_FIRMWARE   = 4'h3,
        PAT_MEMTEST    = 4'h4,
        PAT_CFG_LOAD   = 4'h5,
        PAT_CFG_WAIT   = 4'h6,
        PAT_NOT_CONFIG = 4'h7,
        PAT_RUN        = 4'h8,
        PAT_HEALTHY    = 4'h9
    } pattern_t;

    // module state indications from firmware and host logic
    typedef struct packed {
        logic diag_running;
        logic memtest_running;
        logic fw_checksum_bad;
        logic fw_loading;
        logic cfg_loading;
        logic cfg_waiting;
        logic not_configured;
        logic configured_ok;
        logic status_scanned;
        logic fatal_error;
    } module_state_t;

    // lamp outputs for one channel
    typedef struct packed {
        logic carrier_lamp;
        logic transmit_lamp;
    } chan_lamps_t;
endpackage

// File: blink_divider.sv
// enable-pulse divider and blink phase toggle
`timescale 1ns/1ns
`default_nettype none
module blink_divider #(
    parameter int unsigned HALF_CYC = 4
) (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      phase_q
);
    localparam int unsigned CW = $clog2(HALF_CYC);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] count_q;
    logic          tick;

    assign tick = (count_q == LAST);

    // free-running counter, tick is a one-cycle enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    // blink phase flips once per half period
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_q <= 1'b0;
        end else if (tick) begin
            phase_q <= ~phase_q;
        end
    end
endmodule
`default_nettype wire

// File: status_led_indicator.sv
// front-panel lamp driver for the fieldbus bus_controller_module
//
// Behaviour
// - health lamp blinks in diagnostics, then steady
// - operational lamp lit while host scans status
// - carrier and transmit lamp per channel
// - carrier lamp follows sensed carrier
// - transmit lamp driven by transmit enable
// - configured: both lamps steadily on
// - unconfigured or handheld session: health only
// - waiting configuration: operational blinks slowly
// - loading configuration: operational blinks rapidly
// - memory test: health blinks, operational off
// - firmware fault or load: blink together
// - fatal error: blink in opposite phase
`timescale 1ns/1ns
`default_nettype none
module status_led_indicator
    import lamp_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire module_state_t                state_in,
    input  wire logic                         handheld_programmer_active,
    input  wire logic [NUM_CHANNELS-1:0]      carrier_sense,
    input  wire logic [NUM_CHANNELS-1:0]      transmit_enable,
    output logic                              health_lamp,
    output logic                              run_lamp,
    output chan_lamps_t [NUM_CHANNELS-1:0]    chan_lamps,
    output pattern_t                          pattern
);
    logic     slow_phase;
    logic     fast_phase;
    pattern_t pat_d;
    pattern_t pat_q;
    logic     health_d;
    logic     run_d;
    logic     health_q;
    logic     run_q;
    logic     fw_fault;
    logic     cfg_absent;
    logic     host_running;

    // behaviour of one lamp inside a pattern
    typedef enum logic [2:0] {
        LAMP_DARK     = 3'h0,
        LAMP_LIT      = 3'h1,
        LAMP_SLOW     = 3'h2,
        LAMP_SLOW_INV = 3'h3,
        LAMP_FAST     = 3'h4
    } lamp_mode_t;

    lamp_mode_t health_mode_w;
    lamp_mode_t run_mode_w;

    // pattern to lamp behaviour, kept apart from the phases so that
    // a new pattern only needs a row here, not new blink logic
    function automatic lamp_mode_t health_mode(
        input pattern_t p
    );
        lamp_mode_t m;
        m = LAMP_DARK;
        case (p)
            PAT_FATAL: begin
                m = LAMP_SLOW;
            end
            PAT_FIRMWARE: begin
                m = LAMP_SLOW;
            end
            PAT_MEMTEST: begin
                m = LAMP_SLOW;
            end
            PAT_DIAG: begin
                m = LAMP_SLOW;
            end
            PAT_CFG_LOAD: begin
                m = LAMP_LIT;
            end
            PAT_CFG_WAIT: begin
                m = LAMP_LIT;
            end
            PAT_NOT_CONFIG: begin
                m = LAMP_LIT;
            end
            PAT_RUN: begin
                m = LAMP_LIT;
            end
            PAT_HEALTHY: begin
                m = LAMP_LIT;
            end
            default: begin
                m = LAMP_DARK;
            end
        endcase
        return m;
    endfunction

    // operational lamp behaviour for each pattern
    function automatic lamp_mode_t run_mode(
        input pattern_t p
    );
        lamp_mode_t m;
        m = LAMP_DARK;
        case (p)
            PAT_FATAL: begin
                m = LAMP_SLOW_INV;
            end
            PAT_FIRMWARE: begin
                m = LAMP_SLOW;
            end
            PAT_MEMTEST: begin
                m = LAMP_DARK;
            end
            PAT_DIAG: begin
                m = LAMP_DARK;
            end
            PAT_CFG_LOAD: begin
                m = LAMP_FAST;
            end
            PAT_CFG_WAIT: begin
                m = LAMP_SLOW;
            end
            PAT_NOT_CONFIG: begin
                m = LAMP_DARK;
            end
            PAT_RUN: begin
                m = LAMP_LIT;
            end
            PAT_HEALTHY: begin
                m = LAMP_DARK;
            end
            default: begin
                m = LAMP_DARK;
            end
        endcase
        return m;
    endfunction

    // one lamp level from its behaviour and the two blink phases
    function automatic logic drive_level(
        input lamp_mode_t m,
        input logic       slow,
        input logic       fast
    );
        logic lvl;
        lvl = 1'b0;
        case (m)
            LAMP_LIT: begin
                lvl = 1'b1;
            end
            LAMP_SLOW: begin
                lvl = slow;
            end
            LAMP_SLOW_INV: begin
                lvl = ~slow;
            end
            LAMP_FAST: begin
                lvl = fast;
            end
            default: begin
                lvl = 1'b0;
            end
        endcase
        return lvl;
    endfunction

    // two blink rates from separate dividers
    blink_divider #(.HALF_CYC(SLOW_HALF)) slow_div (
        .clk     (clk),
        .rst_b   (rst_b),
        .phase_q (slow_phase)
    );
    blink_divider #(.HALF_CYC(FAST_HALF)) fast_div (
        .clk     (clk),
        .rst_b   (rst_b),
        .phase_q (fast_phase)
    );

    // condition groups that share one rung of the priority chain
    assign fw_fault     = state_in.fw_checksum_bad || state_in.fw_loading;
    assign cfg_absent   = state_in.not_configured || handheld_programmer_active;
    assign host_running = state_in.configured_ok || state_in.status_scanned;

    // priority select; fatal wins since nothing else is trustworthy then
    always_comb begin
        if (state_in.fatal_error) begin
            pat_d = PAT_FATAL;
        end else if (fw_fault) begin
            pat_d = PAT_FIRMWARE;
        end else if (state_in.memtest_running) begin
            pat_d = PAT_MEMTEST;
        end else if (state_in.diag_running) begin
            pat_d = PAT_DIAG;
        end else if (state_in.cfg_loading) begin
            pat_d = PAT_CFG_LOAD;
        end else if (state_in.cfg_waiting) begin
            pat_d = PAT_CFG_WAIT;
        end else if (cfg_absent) begin
            pat_d = PAT_NOT_CONFIG;
        end else if (host_running) begin
            pat_d = PAT_RUN;
        end else begin
            pat_d = PAT_HEALTHY;
        end
    end

    // lamp levels for the registered pattern; each lamp has its own mode decode, both share drive_level
    always_comb begin
        health_mode_w = health_mode(pat_q);
        run_mode_w    = run_mode(pat_q);
        health_d      = drive_level(health_mode_w, slow_phase, fast_phase);
        run_d         = drive_level(run_mode_w, slow_phase, fast_phase);
    end

    // registered pattern, dark in reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pat_q <= PAT_OFF;
        end else begin
            pat_q <= pat_d;
        end
    end

    // health lamp from a flip-flop so it never glitches
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            health_q <= 1'b0;
        end else begin
            health_q <= health_d;
        end
    end

    // operational lamp from a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_d;
        end
    end

    assign health_lamp = health_q;
    assign run_lamp    = run_q;
    assign pattern     = pat_q;

    // per-channel lamps; inputs come from the protocol engine's domain
    // a lone disagreeing sample between the last two stages is ignored,
    // so a late settle cannot flash a lamp for a single cycle
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            logic [SYNC_STAGES-1:0] cd_sync_q;
            logic [SYNC_STAGES-1:0] tx_sync_q;
            logic                   cd_q;
            logic                   tx_q;

            // carrier capture chain; stage 0 only feeds stage 1
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cd_sync_q <= '0;
                end else begin
                    cd_sync_q <= {cd_sync_q[SYNC_STAGES-2:0], carrier_sense[ch]};
                end
            end

            // transmit capture chain; stage 0 only feeds stage 1
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    tx_sync_q <= '0;
                end else begin
                    tx_sync_q <= {tx_sync_q[SYNC_STAGES-2:0], transmit_enable[ch]};
                end
            end

            // carrier change accepted when last two stages agree
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    cd_q <= 1'b0;
                end else if (cd_sync_q[SYNC_STAGES-2] == cd_sync_q[SYNC_STAGES-1]) begin
                    cd_q <= cd_sync_q[SYNC_STAGES-1];
                end
            end

            // transmit lamp follows the synchronised enable once the last two stages agree
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    tx_q <= 1'b0;
                end else if (tx_sync_q[SYNC_STAGES-2] == tx_sync_q[SYNC_STAGES-1]) begin
                    tx_q <= tx_sync_q[SYNC_STAGES-1];
                end
            end

            // one driver for the whole channel struct
            assign chan_lamps[ch] = {cd_q, tx_q};
        end
    endgenerate
endmodule
`default_nettype wire

// File: status_led_indicator_monitor.sv
// assertion checker for the status lamp driver
`timescale 1ns/1ns
`default_nettype none
module status_led_indicator_monitor
    import lamp_pkg::*;
#(
    parameter int unsigned SLOW_HALF = 8,
    parameter int unsigned FAST_HALF = 2
) (
    input wire logic                        clk,
    input wire logic                        rst_b,
    input wire module_state_t               state_in,
    input wire logic [NUM_CHANNELS-1:0]     carrier_sense,
    input wire logic [NUM_CHANNELS-1:0]     transmit_enable,
    input wire logic                        health_lamp,
    input wire logic                        run_lamp,
    input wire chan_lamps_t [NUM_CHANNELS-1:0] chan_lamps,
    input wire pattern_t                    pattern
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // cycles since the run lamp last changed, to measure blink half period
    logic [31:0] since_q;
    logic        run_prev_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_prev_q <= 1'b0;
            since_q    <= 32'h0;
        end else begin
            run_prev_q <= run_lamp;
            since_q    <= (run_lamp != run_prev_q) ? 32'h1 : since_q + 32'h1;
        end
    end
    // pattern held long enough that a whole lamp period lies inside it
    sequence s_settled(pattern_t p);
        (pattern == p)[*8] ##1 (pattern == p)[*8] ##1 (pattern == p && run_lamp != run_prev_q);
    endsequence
    sequence s_lines_quiet;
        $stable({carrier_sense, transmit_enable})[*6];
    endsequence
    a_fatal_alternate:
        assert property ($past(pattern) == PAT_FATAL |-> health_lamp != run_lamp) else $error("fatal phase");
    a_firmware_together:
        assert property ($past(pattern) == PAT_FIRMWARE |-> health_lamp == run_lamp) else $error("firmware phase");
    a_memtest_run_off:
        assert property ($past(pattern) == PAT_MEMTEST |-> !run_lamp) else $error("memtest run lamp");
    a_config_both_on:
        assert property ($past(pattern) == PAT_RUN |-> health_lamp && run_lamp) else $error("configured lamps");
    a_unconfig_health_only:
        assert property ($past(pattern) == PAT_NOT_CONFIG |-> health_lamp && !run_lamp) else $error("unconfigured");
    a_loading_fast_blink:
        assert property (s_settled(PAT_CFG_LOAD) |-> since_q == FAST_HALF && health_lamp) else $error("fast blink");
    a_waiting_slow_blink:
        assert property (s_settled(PAT_CFG_WAIT) |-> since_q == SLOW_HALF && health_lamp) else $error("slow blink");
    a_fatal_wins:
        assert property ($past(rst_b) && state_in.fatal_error |=> pattern == PAT_FATAL) else $error("priority");
    a_channels_follow:
        assert property (s_lines_quiet |-> chan_lamps == {carrier_sense[1], transmit_enable[1],
            carrier_sense[0], transmit_enable[0]}) else $error("channel lamps");
endmodule
bind status_led_indicator status_led_indicator_monitor #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) i_mon (
    .clk(clk), .rst_b(rst_b), .state_in(state_in), .carrier_sense(carrier_sense),
    .transmit_enable(transmit_enable), .health_lamp(health_lamp), .run_lamp(run_lamp),
    .chan_lamps(chan_lamps), .pattern(pattern));
`default_nettype wire

// File: lamp_panel_model.sv
// operator's view of the panel: counts health lamp flashes
`timescale 1ns/1ns
`default_nettype none
module lamp_panel_model (
    input  wire logic        clk,
    input  wire logic        health_lamp,
    output logic [15:0]      flashes
);
    logic seen_q = 1'b0;
    initial flashes = 16'h0;
    // an operator notices each off-to-on change, not the steady level
    always @(posedge clk) begin
        if (health_lamp && !seen_q)
            flashes <= flashes + 16'h1;
        seen_q <= health_lamp;
    end
endmodule
`default_nettype wire

// File: status_led_indicator_tb.sv
// self-checking bench for the status lamp driver
`timescale 1ns/1ns
`default_nettype none
module status_led_indicator_tb
    import lamp_pkg::*;
();
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    module_state_t     st = '0;
    logic              hh = 1'b0;
    logic [1:0]        cs = 2'h0;
    logic [1:0]        te = 2'h0;
    logic              health_lamp;
    logic              run_lamp;
    chan_lamps_t [1:0] chan_lamps;
    pattern_t          pattern;
    logic [15:0]       flashes;
    int                miscompares = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    // {handheld, state bits, expected pattern}; ordered to strip priorities one by one
    logic [15:0] tbl[13] = '{16'h3FF2, 16'h3FE3, 16'h0403, 16'h3004, 16'h13E4, 16'h2001, 16'h03E5,
        16'h01E6, 16'h00E7, 16'h0068, 16'h0028, 16'h4047, 16'h0009};
    always #4 clk = ~clk;
    status_led_indicator #(.SLOW_HALF(8), .FAST_HALF(2)) i_dut (.clk(clk), .rst_b(rst_b), .state_in(st),
        .handheld_programmer_active(hh), .carrier_sense(cs), .transmit_enable(te), .health_lamp(health_lamp),
        .run_lamp(run_lamp), .chan_lamps(chan_lamps), .pattern(pattern));
    lamp_panel_model i_panel (.clk(clk), .health_lamp(health_lamp), .flashes(flashes));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // each condition set held long enough for two slow blink periods
    task automatic t_patterns();
        logic [15:0] base;
        logic [3:0]  p;
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            {hh, st} <= tbl[i][14:4];
            p = tbl[i][3:0];
            repeat (4) @(posedge clk);
            #1 base = flashes;
            repeat (36) @(posedge clk);
            #1;
            chk({4'h0, pattern}, {4'h0, p});
            chk({7'h0, flashes != base}, {7'h0, p inside {4'h1, 4'h2, 4'h3, 4'h4}});
            if (p > 4'h6)
                chk({6'h0, health_lamp, run_lamp}, {6'h0, 1'b1, p == 4'h8});
        end
    endtask
    // all four carrier patterns, transmit the inverse, to catch crossed lamps
    task automatic t_channels();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            cs <= k[1:0];
            te <= ~k[1:0];
            repeat (6) @(posedge clk);
            #1;
            chk({4'h0, chan_lamps}, {4'h0, k[1], ~k[1], k[0], ~k[0]});
        end
    endtask
    // hang guard: the run needs under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_patterns();
        t_channels();
        final_report();
    end
endmodule
`default_nettype wire
